//--- common/ilpd_pkg.sv
package ilpd_pkg;
  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int INSN_W = 10;
  localparam int NIB_W = 4;
  localparam int BANK_W = 2;
  localparam int PC_W = 13;

  // ---------------------------------------------------------------
  // Opcode patterns and field positions
  // ---------------------------------------------------------------
  localparam logic [INSN_W-1:0] OPC_NOP = 10'h000;
  localparam logic [INSN_W-1:0] OPC_PORT0 = 10'h221;
  localparam logic [INSN_W-1:0] OPC_PORT1 = 10'h222;
  localparam logic [5:0] OPC_LA_HI = 6'h07;
  localparam logic [1:0] OPC_LXY_HI = 2'h3;
  localparam logic [7:0] OPC_LZ_HI = 8'h12;
  localparam int IMM_LO = 0;
  localparam int X_LO = 4;
  localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
  localparam logic [PC_W-1:0] PC_RST = 13'h0000;
  localparam logic [NIB_W-1:0] NIB_RST = 4'h0;
  localparam logic [BANK_W-1:0] BANK_RST = 2'h0;

  // ---------------------------------------------------------------
  // Decoded classes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ILPD_OTHER = 3'b000,
    ILPD_NOP = 3'b001,
    ILPD_LOAD_WORK = 3'b010,
    ILPD_LOAD_PAIR = 3'b011,
    ILPD_LOAD_BANK = 3'b100,
    ILPD_PORT0 = 3'b101,
    ILPD_PORT1 = 3'b110
  } ilpd_class_t;
endpackage : ilpd_pkg

//--- hw/ilpd_core.sv
// Notes on behaviour
// - Immediate load writes the 4-bit value into the work register.
// - In a run of immediate loads only the first executes.
// - Pointer-pair load puts high nibble in column, low nibble in file pointer.
// - In a run of pointer-pair loads only the first executes.
// - Bank-select load writes the 2-bit immediate into the bank register.
// - All-zero word only advances the program counter by one.
// - Port-zero output copies the work register onto port zero.
// - Port-one output copies the work register onto port one.
module ilpd_core (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [ilpd_pkg::INSN_W-1:0] insn_i,
  output logic [ilpd_pkg::PC_W-1:0] program_counter_o,
  output logic [ilpd_pkg::NIB_W-1:0] work_reg_o,
  output logic [ilpd_pkg::NIB_W-1:0] column_ptr_o,
  output logic [ilpd_pkg::NIB_W-1:0] file_ptr_o,
  output logic [ilpd_pkg::BANK_W-1:0] bank_sel_o,
  output logic [ilpd_pkg::NIB_W-1:0] output_port_zero_o,
  output logic [ilpd_pkg::NIB_W-1:0] output_port_one_o,
  output logic skipped_o
);
  import ilpd_pkg::*;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  // The word comes from program memory on this clock, so no synchroniser.
  function automatic ilpd_class_t classify(input logic [INSN_W-1:0] w);
    if (w == OPC_NOP) begin
      return ILPD_NOP;
    end else if (w == OPC_PORT0) begin
      return ILPD_PORT0;
    end else if (w == OPC_PORT1) begin
      return ILPD_PORT1;
    end else if (w[INSN_W-1 -: $bits(OPC_LA_HI)] == OPC_LA_HI) begin
      return ILPD_LOAD_WORK;
    end else if (w[INSN_W-1 -: $bits(OPC_LXY_HI)] == OPC_LXY_HI) begin
      return ILPD_LOAD_PAIR;
    end else if (w[INSN_W-1 -: $bits(OPC_LZ_HI)] == OPC_LZ_HI) begin
      return ILPD_LOAD_BANK;
    end else begin
      return ILPD_OTHER;
    end
  endfunction : classify

  ilpd_class_t cls;
  ilpd_class_t prev_cls;
  ilpd_class_t next_prev_cls;
  logic skip_now;
  logic [PC_W-1:0] pc;
  logic [PC_W-1:0] next_pc;
  logic [NIB_W-1:0] work;
  logic [NIB_W-1:0] next_work;
  logic [NIB_W-1:0] col;
  logic [NIB_W-1:0] next_col;
  logic [NIB_W-1:0] fil;
  logic [NIB_W-1:0] next_fil;
  logic [BANK_W-1:0] bank;
  logic [BANK_W-1:0] next_bank;
  logic [NIB_W-1:0] port0;
  logic [NIB_W-1:0] next_port0;
  logic [NIB_W-1:0] port1;
  logic [NIB_W-1:0] next_port1;
  logic skipped;
  logic next_skipped;

  assign cls = classify(insn_i);

  // ---------------------------------------------------------------
  // Execute
  // ---------------------------------------------------------------
  always_comb begin
    next_pc = pc + PC_STEP;
    next_work = work;
    next_col = col;
    next_fil = fil;
    next_bank = bank;
    next_port0 = port0;
    next_port1 = port1;
    next_prev_cls = cls;
    // Run detection: an immediate or pointer-pair load that follows a load of the same kind is skipped.
    skip_now = 1'b0;
    if (cls == ILPD_LOAD_WORK && prev_cls == ILPD_LOAD_WORK) begin
      skip_now = 1'b1;
    end
    if (cls == ILPD_LOAD_PAIR && prev_cls == ILPD_LOAD_PAIR) begin
      skip_now = 1'b1;
    end
    next_skipped = skip_now;
    if (!skip_now) begin
      case (cls)
        ILPD_LOAD_WORK: begin
          next_work = insn_i[IMM_LO +: NIB_W];
        end
        ILPD_LOAD_PAIR: begin
          next_col = insn_i[X_LO +: NIB_W];
          next_fil = insn_i[IMM_LO +: NIB_W];
        end
        ILPD_LOAD_BANK: begin
          next_bank = insn_i[IMM_LO +: BANK_W];
        end
        ILPD_PORT0: begin
          next_port0 = work;
        end
        ILPD_PORT1: begin
          next_port1 = work;
        end
        ILPD_NOP: begin
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pc <= PC_RST;
      work <= NIB_RST;
      col <= NIB_RST;
      fil <= NIB_RST;
      bank <= BANK_RST;
      port0 <= NIB_RST;
      port1 <= NIB_RST;
      prev_cls <= ILPD_OTHER;
      skipped <= 1'b0;
    end else begin
      pc <= next_pc;
      work <= next_work;
      col <= next_col;
      fil <= next_fil;
      bank <= next_bank;
      port0 <= next_port0;
      port1 <= next_port1;
      prev_cls <= next_prev_cls;
      skipped <= next_skipped;
    end
  end

  assign program_counter_o = pc;
  assign work_reg_o = work;
  assign column_ptr_o = col;
  assign file_ptr_o = fil;
  assign bank_sel_o = bank;
  assign output_port_zero_o = port0;
  assign output_port_one_o = port1;
  assign skipped_o = skipped;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  // Antecedents also need reset high as sampled, because at the last reset edge the
  // registers are still cleared while the release is already visible to disable iff.
  property p_load_work;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (rst_n_i && cls == ILPD_LOAD_WORK && prev_cls != ILPD_LOAD_WORK) |=>
      work == $past(insn_i[IMM_LO +: NIB_W]);
  endproperty
  a_load_work: assert property (p_load_work) else $error("work load wrong");

  property p_skip_work;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (rst_n_i && cls == ILPD_LOAD_WORK && prev_cls == ILPD_LOAD_WORK) |=>
      $stable(work) && skipped;
  endproperty
  a_skip_work: assert property (p_skip_work) else $error("repeat load ran");

  property p_load_pair;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (rst_n_i && cls == ILPD_LOAD_PAIR && prev_cls != ILPD_LOAD_PAIR) |=>
      col == $past(insn_i[X_LO +: NIB_W]) && fil == $past(insn_i[IMM_LO +: NIB_W]);
  endproperty
  a_load_pair: assert property (p_load_pair) else $error("pair load wrong");

  property p_skip_pair;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (rst_n_i && cls == ILPD_LOAD_PAIR && prev_cls == ILPD_LOAD_PAIR) |=>
      $stable(col) && $stable(fil) && skipped;
  endproperty
  a_skip_pair: assert property (p_skip_pair) else $error("repeat pair ran");

  property p_load_bank;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    rst_n_i && cls == ILPD_LOAD_BANK |=> bank == $past(insn_i[IMM_LO +: BANK_W]);
  endproperty
  a_load_bank: assert property (p_load_bank) else $error("bank load wrong");

  property p_nop;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    rst_n_i && cls == ILPD_NOP |=> pc == $past(pc) + PC_STEP && $stable(work) && $stable(bank)
      && $stable(col) && $stable(fil) && $stable(port0) && $stable(port1);
  endproperty
  a_nop: assert property (p_nop) else $error("nop changed state");

  property p_port0;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    rst_n_i && cls == ILPD_PORT0 |=>
      output_port_zero_o == $past(work) && $stable(output_port_one_o);
  endproperty
  a_port0: assert property (p_port0) else $error("port zero wrong");

  property p_port1;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    rst_n_i && cls == ILPD_PORT1 |=>
      output_port_one_o == $past(work) && $stable(output_port_zero_o);
  endproperty
  a_port1: assert property (p_port1) else $error("port one wrong");

  property p_pc_step;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $past(rst_n_i) |-> pc == $past(pc) + PC_STEP;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("pc did not step");

  c_work_run: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    cls == ILPD_LOAD_WORK ##1 cls == ILPD_LOAD_WORK ##1 cls == ILPD_LOAD_WORK);
  c_pair_run: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    cls == ILPD_LOAD_PAIR ##1 cls == ILPD_LOAD_PAIR);
  c_load_out: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    cls == ILPD_LOAD_WORK ##1 cls == ILPD_PORT1);
endmodule : ilpd_core

//--- sim/ilpd_prog_mem.sv
// ------------------------------------------------------------
// Program memory seen by the decoder
// ------------------------------------------------------------
module ilpd_prog_mem (
  input wire logic [ilpd_pkg::PC_W-1:0] addr_i,
  output logic [ilpd_pkg::INSN_W-1:0] insn_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import ilpd_pkg::*;
  logic [INSN_W-1:0] mem [0:255];
  // Only 256 words are modelled, so the address wraps well before the counter does.
  assign insn_o = mem[addr_i[7:0]];
endmodule : ilpd_prog_mem

//--- sim/immediate_load_port_out_decode_tb_top.sv
module immediate_load_port_out_decode_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ilpd_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [INSN_W-1:0] insn;
  logic [PC_W-1:0] pc;
  logic [NIB_W-1:0] wk, cx, fy, p0, p1;
  logic [BANK_W-1:0] bk;
  logic sk;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int m_pc, m_wk, m_cx, m_fy, m_bk, m_p0, m_p1, m_sk, m_prev;
  logic [INSN_W-1:0] dir [0:14] = '{10'h075, 10'h07a, 10'h07c, 10'h221, 10'h3a7, 10'h3b8,
    10'h04b, 10'h000, 10'h222, 10'h07f, 10'h000, 10'h07e, 10'h222, 10'h3c1, 10'h048};

  always #2 sys_clk = ~sys_clk;

  ilpd_prog_mem i_ilpd_prog_mem (.addr_i(pc), .insn_o(insn));
  ilpd_core i_ilpd_core (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .insn_i(insn),
    .program_counter_o(pc), .work_reg_o(wk), .column_ptr_o(cx), .file_ptr_o(fy),
    .bank_sel_o(bk), .output_port_zero_o(p0), .output_port_one_o(p1), .skipped_o(sk));

  // ------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    if (bad_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  // Far more cycles than the 264 the program needs.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles >= 1000) begin
      bad_count++;
      end_sim();
    end
  end

  // ------------------------------------------------------------
  // Reference model
  // ------------------------------------------------------------
  task automatic step(input logic [INSN_W-1:0] w);
    int c;
    c = 0;
    if (w == 10'h000) c = 1;
    else if (w == 10'h221) c = 4;
    else if (w == 10'h222) c = 5;
    else if (w[9:4] == 6'h07) c = 2;
    else if (w[9:8] == 2'h3) c = 3;
    else if (w[9:2] == 8'h12) c = 6;
    // A skipped load still extends the run it belongs to.
    m_sk = (c == 2 || c == 3) && c == m_prev;
    m_prev = c;
    m_pc = (m_pc + 1) % 8192;
    if (!m_sk) begin
      case (c)
        2: m_wk = w[3:0];
        3: begin
          m_cx = w[7:4];
          m_fy = w[3:0];
        end
        4: m_p0 = m_wk;
        5: m_p1 = m_wk;
        6: m_bk = w[1:0];
        default: ;
      endcase
    end
  endtask : step

  function automatic logic [INSN_W-1:0] rand_word();
    logic [INSN_W-1:0] r;
    r = 10'($urandom);
    case ($urandom % 8)
      0: rand_word = {6'h07, r[3:0]};
      1: rand_word = {2'h3, r[7:0]};
      2: rand_word = {8'h12, r[1:0]};
      3: rand_word = 10'h000;
      4: rand_word = 10'h221;
      5: rand_word = 10'h222;
      default: rand_word = r;
    endcase
  endfunction : rand_word

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [INSN_W-1:0] w;
    void'($urandom(32'h95eeca14));
    for (int k = 0; k < 256; k++) begin
      i_ilpd_prog_mem.mem[k] = (k < 15) ? dir[k] : rand_word();
    end
    {m_pc, m_wk, m_cx, m_fy, m_bk, m_p0, m_p1, m_sk, m_prev} = '0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 256; k++) begin
      w = insn;
      @(posedge sys_clk);
      #1;
      step(w);
      check("program_counter", 16'(pc), 16'(m_pc));
      check("work_reg", 16'(wk), 16'(m_wk));
      check("column_ptr", 16'(cx), 16'(m_cx));
      check("file_ptr", 16'(fy), 16'(m_fy));
      check("bank_sel", 16'(bk), 16'(m_bk));
      check("output_port_zero", 16'(p0), 16'(m_p0));
      check("output_port_one", 16'(p1), 16'(m_p1));
      check("skipped", 16'(sk), 16'(m_sk));
    end
    end_sim();
  end
endmodule : immediate_load_port_out_decode_tb_top
